// ===== src/ies_pkg.sv
// package: offsets, field positions, codes and reset values of the first event group
package ies_pkg;

  // ==========================================================================
  // host offsets
  localparam logic [4:0] OFF_A_DATA = 5'h01;
  localparam logic [4:0] OFF_B_DATA = 5'h11;
  localparam logic [4:0] OFF_A_EVENT = 5'h03;
  localparam logic [4:0] OFF_B_EVENT = 5'h13;
  localparam logic [4:0] OFF_A_AUX = 5'h09;
  localparam logic [4:0] OFF_B_AUX = 5'h19;
  localparam logic [4:0] OFF_A_TERM = 5'h0f;
  localparam logic [4:0] OFF_B_TERM = 5'h1f;

  // ==========================================================================
  // field positions of the status and enable registers
  localparam int BIT_UNKNOWN = 7;
  localparam int BIT_SECONDARY = 6;
  localparam int BIT_TRIGGER = 5;
  localparam int BIT_END = 4;
  localparam int BIT_CLEAR = 3;
  localparam int BIT_LOST = 2;
  localparam int BIT_OUT_READY = 1;
  localparam int BIT_IN_BYTE = 0;

  // ==========================================================================
  // auxiliary command codes and reset values
  localparam logic [7:0] AUX_VALID = 8'h0f;
  localparam logic [7:0] AUX_NON_VALID = 8'h07;
  localparam logic [7:0] AUX_FINISH = 8'h03;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // pick the port A or port B copy of an offset
  function automatic logic [4:0] port_off(input logic sel, input logic [4:0] a,
                                          input logic [4:0] b);
    port_off = sel ? b : a;
  endfunction

endpackage

// ===== src/ies_flag_if.sv
// interface: top logic to the status flag bank
interface ies_flag_if;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic read_busy;
  logic read_done;
  logic enable_wr;
  logic [7:0] wdata;
  logic [7:0] flags;
  logic [7:0] enable;
  logic [7:0] next_flags;
  modport ctrl (output set_vec, clr_vec, read_busy, read_done, enable_wr, wdata,
                input flags, enable, next_flags);
  modport bank (input set_vec, clr_vec, read_busy, read_done, enable_wr, wdata,
                output flags, enable, next_flags);
endinterface

// ===== src/ies_flag_bank.sv
// module: status flags, read hold-off and write-only enable register
module ies_flag_bank (
  input wire logic clk,
  input wire logic reset,
  ies_flag_if.bank fb
);
  logic [7:0] pend;
  logic [7:0] next_pend;

  // =========================================================================
  // next flag value; sets during a read are parked, set wins over clear
  always_comb begin
    next_pend = pend | fb.set_vec;
    fb.next_flags = (fb.flags & ~fb.clr_vec) | fb.set_vec;
    if (fb.read_busy) begin
      fb.next_flags = fb.flags & ~fb.clr_vec;
    end
    if (fb.read_done) begin
      fb.next_flags = next_pend;
    end
  end

  // flag register
  always_ff @(posedge clk) begin
    if (reset) begin
      fb.flags <= ies_pkg::STATUS_RESET;
    end else begin
      fb.flags <= fb.next_flags;
    end
  end

  // parked sets, emptied when the read finishes
  always_ff @(posedge clk) begin
    if (reset || fb.read_done || !fb.read_busy) begin
      pend <= ies_pkg::STATUS_RESET;
    end else begin
      pend <= next_pend;
    end
  end

  // enable register, write only
  always_ff @(posedge clk) begin
    if (reset) begin
      fb.enable <= ies_pkg::ENABLE_RESET;
    end else if (fb.enable_wr) begin
      fb.enable <= fb.wdata;
    end
  end
endmodule

// ===== src/ies_pass_through.sv
// module: undefined-primary tracking, acceptor stall and pass-through byte
module ies_pass_through (
  input wire logic clk,
  input wire logic reset,
  input wire logic accept,
  input wire logic [7:0] bus_byte,
  input wire logic ucg,
  input wire logic acg,
  input wire logic scg,
  input wire logic tag,
  input wire logic lag,
  input wire logic cmd_defined,
  input wire logic tads,
  input wire logic lads,
  input wire logic tpas,
  input wire logic lpas,
  input wire logic pass_through_on,
  input wire logic address_mode_high,
  input wire logic address_mode_low,
  input wire logic aux_valid,
  input wire logic aux_non_valid,
  output logic unknown_hit,
  output logic secondary_hit,
  output logic hold,
  output logic [7:0] readback
);
  logic undefined_primary_pending;
  logic cmd_group;
  logic undef_hit;
  logic def_hit;

  // =========================================================================
  // command decode; addressed commands count as undefined only when addressed
  assign cmd_group = ucg | (acg & (tads | lads));
  assign undef_hit = cmd_group & ~cmd_defined & accept & pass_through_on;
  assign def_hit = (((ucg | acg) & cmd_defined) | tag | lag) & accept;
  assign unknown_hit = undef_hit | (undefined_primary_pending & scg & accept
                       & pass_through_on);
  assign secondary_hit = address_mode_high & address_mode_low & (tpas | lpas)
                         & scg & accept;

  // undefined-primary tracking state
  always_ff @(posedge clk) begin
    if (reset || !pass_through_on) begin
      undefined_primary_pending <= 1'b0;
    end else if (undef_hit) begin
      undefined_primary_pending <= 1'b1;
    end else if (def_hit) begin
      undefined_primary_pending <= 1'b0;
    end
  end

  // acceptor stall until the host releases it
  always_ff @(posedge clk) begin
    if (reset) begin
      hold <= 1'b0;
    end else if (unknown_hit || secondary_hit) begin
      hold <= 1'b1;
    end else if (aux_valid || aux_non_valid) begin
      hold <= 1'b0;
    end
  end

  // byte kept for the host to inspect
  always_ff @(posedge clk) begin
    if (reset) begin
      readback <= ies_pkg::BYTE_RESET;
    end else if (unknown_hit || secondary_hit) begin
      readback <= bus_byte;
    end
  end
endmodule

// ===== src/ies_event_one.sv
// module: first event status group with enables, pass-through and interrupt
module ies_event_one #(
  parameter logic PORT_SEL = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic [7:0] bus_byte,
  input wire logic tacs,
  input wire logic sgns,
  input wire logic sdys,
  input wire logic sids,
  input wire logic dac,
  input wire logic rfd,
  input wire logic lacs,
  input wire logic acds,
  input wire logic eoi,
  input wire logic ucg,
  input wire logic acg,
  input wire logic scg,
  input wire logic tag,
  input wire logic lag,
  input wire logic cmd_defined,
  input wire logic tads,
  input wire logic lads,
  input wire logic tpas,
  input wire logic lpas,
  input wire logic dtas,
  input wire logic dcas,
  input wire logic pass_through_on,
  input wire logic string_match_allow,
  input wire logic address_mode_high,
  input wire logic address_mode_low,
  input wire logic continuous_mode,
  input wire logic holdoff_mode,
  input wire logic group_two_pending,
  output logic irq,
  output logic acceptor_hold,
  output logic [7:0] pass_through_readback
);
  ies_flag_if fb ();

  logic [4:0] off_event;
  logic [4:0] off_data;
  logic [4:0] off_aux;
  logic [4:0] off_term;
  logic sel_event;
  logic sel_data;
  logic sel_aux;
  logic sel_term;
  logic rd_q;
  logic acds_q;
  logic dtas_q;
  logic dcas_q;
  logic sdys_q;
  logic no_listener_q;
  logic talk_gen_q;
  logic accept;
  logic no_listener;
  logic talk_gen;
  logic data_write;
  logic aux_write;
  logic aux_valid;
  logic aux_non_valid;
  logic aux_finish;
  logic unknown_hit;
  logic secondary_hit;
  logic hold;
  logic [7:0] readback;
  logic [7:0] terminator;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] next_rdata;

  // ==========================================================================
  // address decode for this port copy
  assign off_event = ies_pkg::port_off(PORT_SEL, ies_pkg::OFF_A_EVENT,
                                       ies_pkg::OFF_B_EVENT);
  assign off_data = ies_pkg::port_off(PORT_SEL, ies_pkg::OFF_A_DATA,
                                      ies_pkg::OFF_B_DATA);
  assign off_aux = ies_pkg::port_off(PORT_SEL, ies_pkg::OFF_A_AUX,
                                     ies_pkg::OFF_B_AUX);
  assign off_term = ies_pkg::port_off(PORT_SEL, ies_pkg::OFF_A_TERM,
                                      ies_pkg::OFF_B_TERM);
  assign sel_event = (host_addr == off_event);
  assign sel_data = (host_addr == off_data);
  assign sel_aux = (host_addr == off_aux);
  assign sel_term = (host_addr == off_term);

  // write strobes
  assign data_write = host_wr & sel_data;
  assign aux_write = host_wr & sel_aux;
  assign aux_valid = aux_write & (host_wdata == ies_pkg::AUX_VALID);
  assign aux_non_valid = aux_write & (host_wdata == ies_pkg::AUX_NON_VALID);
  assign aux_finish = aux_write & (host_wdata == ies_pkg::AUX_FINISH);

  // ==========================================================================
  // history of bus states for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      acds_q <= 1'b0;
      dtas_q <= 1'b0;
      dcas_q <= 1'b0;
      sdys_q <= 1'b0;
      no_listener_q <= 1'b0;
      talk_gen_q <= 1'b0;
    end else begin
      acds_q <= acds;
      dtas_q <= dtas;
      dcas_q <= dcas;
      sdys_q <= sdys;
      no_listener_q <= no_listener;
      talk_gen_q <= talk_gen;
    end
  end

  // one accept event per byte
  assign accept = acds & ~acds_q;
  assign no_listener = tacs & sdys & dac & rfd;
  assign talk_gen = tacs & sgns;

  // ==========================================================================
  // undefined command tracking and acceptor stall
  ies_pass_through u_pass (
    .clk(clk),
    .reset(reset),
    .accept(accept),
    .bus_byte(bus_byte),
    .ucg(ucg),
    .acg(acg),
    .scg(scg),
    .tag(tag),
    .lag(lag),
    .cmd_defined(cmd_defined),
    .tads(tads),
    .lads(lads),
    .tpas(tpas),
    .lpas(lpas),
    .pass_through_on(pass_through_on),
    .address_mode_high(address_mode_high),
    .address_mode_low(address_mode_low),
    .aux_valid(aux_valid),
    .aux_non_valid(aux_non_valid),
    .unknown_hit(unknown_hit),
    .secondary_hit(secondary_hit),
    .hold(hold),
    .readback(readback)
  );

  // ==========================================================================
  // end-of-string terminator, written by the host
  always_ff @(posedge clk) begin
    if (reset) begin
      terminator <= ies_pkg::BYTE_RESET;
    end else if (host_wr && sel_term) begin
      terminator <= host_wdata;
    end
  end

  // ==========================================================================
  // set conditions, one per flag, independent of enables
  always_comb begin
    set_vec = 8'h00;
    set_vec[ies_pkg::BIT_UNKNOWN] = unknown_hit;
    set_vec[ies_pkg::BIT_SECONDARY] = secondary_hit;
    set_vec[ies_pkg::BIT_TRIGGER] = dtas & ~dtas_q;
    set_vec[ies_pkg::BIT_END] = lacs & accept
      & (eoi | (string_match_allow & (bus_byte == terminator)));
    set_vec[ies_pkg::BIT_CLEAR] = dcas & ~dcas_q;
    set_vec[ies_pkg::BIT_LOST] = (no_listener & ~no_listener_q)
      | (sids & data_write) | (sdys_q & sids);
    set_vec[ies_pkg::BIT_OUT_READY] = talk_gen & ~talk_gen_q;
    set_vec[ies_pkg::BIT_IN_BYTE] = lacs & accept & ~continuous_mode;
  end

  // clear conditions other than the status read
  always_comb begin
    clr_vec = 8'h00;
    clr_vec[ies_pkg::BIT_OUT_READY] = ~talk_gen | data_write;
    clr_vec[ies_pkg::BIT_IN_BYTE] = (host_rd & sel_data)
      | (aux_finish & holdoff_mode);
  end

  // ==========================================================================
  // status read cycle: busy while strobe held, done when it drops
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= host_rd & sel_event;
    end
  end

  // flag bank hookup
  assign fb.set_vec = set_vec;
  assign fb.clr_vec = clr_vec;
  assign fb.read_busy = host_rd & sel_event;
  assign fb.read_done = rd_q & ~(host_rd & sel_event);
  assign fb.enable_wr = host_wr & sel_event;
  assign fb.wdata = host_wdata;

  ies_flag_bank u_bank (
    .clk(clk),
    .reset(reset),
    .fb(fb)
  );

  // ==========================================================================
  // read data: status snapshot taken at the start of the read
  always_comb begin
    next_rdata = host_rdata;
    if (host_rd) begin
      next_rdata = 8'h00;
    end
    if (host_rd && sel_event) begin
      next_rdata = rd_q ? host_rdata : fb.flags;
    end
    if (host_rd && sel_aux) begin
      next_rdata = readback;
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata <= ies_pkg::BYTE_RESET;
    end else begin
      host_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // interrupt output
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(fb.next_flags & fb.enable))
             | group_two_pending;
    end
  end

  // stall and byte straight from their flops, so the far side sees the stall
  // in the cycle right after the accept and cannot finish the handshake first
  assign acceptor_hold = hold;
  assign pass_through_readback = readback;

endmodule

// ===== dv/ies_event_one_monitor.sv
// checker: port timing of the first event group
module ies_event_one_monitor #(
  parameter logic PORT_SEL = 1'h0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic [7:0] bus_byte,
  input wire logic acds,
  input wire logic ucg,
  input wire logic scg,
  input wire logic cmd_defined,
  input wire logic tpas,
  input wire logic lpas,
  input wire logic pass_through_on,
  input wire logic address_mode_high,
  input wire logic address_mode_low,
  input wire logic group_two_pending,
  input wire logic irq,
  input wire logic acceptor_hold,
  input wire logic [7:0] pass_through_readback
);
  // ==========
  // helpers
  logic aux_wr;
  // write to the auxiliary command port of this copy
  assign aux_wr = host_wr && host_addr == (PORT_SEL ? ies_pkg::OFF_B_AUX : ies_pkg::OFF_A_AUX);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ==========
  // byte acceptance steps
  sequence s_take;
    $rose(acds) && !acceptor_hold;
  endsequence
  sequence s_unknown;
    s_take ##0 (ucg && !cmd_defined && pass_through_on);
  endsequence
  sequence s_second;
    s_take ##0 (address_mode_high && address_mode_low && scg && (tpas || lpas));
  endsequence

  // ==========
  // assertions
  a_reset_quiet: assert property (
    $fell(reset) |-> !irq && !acceptor_hold && pass_through_readback == 8'h00)
    else $error("outputs not quiet after reset");
  a_unknown_stall: assert property (
    s_unknown |=> acceptor_hold && pass_through_readback == $past(bus_byte))
    else $error("unknown command not held or not captured");
  a_second_stall: assert property (
    s_second |=> acceptor_hold && pass_through_readback == $past(bus_byte))
    else $error("secondary address not held or not captured");
  a_off_no_stall: assert property (
    s_take ##0 (!pass_through_on && !address_mode_high) |=> !acceptor_hold)
    else $error("stall with pass-through off");
  a_hold_stays: assert property (
    acceptor_hold && !aux_wr |=> acceptor_hold)
    else $error("acceptor released without host command");
  a_valid_release: assert property (
    acceptor_hold && aux_wr && (host_wdata == ies_pkg::AUX_VALID ||
      host_wdata == ies_pkg::AUX_NON_VALID) |=> !acceptor_hold)
    else $error("acceptor not released by release code");
  a_group_irq: assert property (
    group_two_pending |=> irq)
    else $error("second group pending without interrupt");
  a_read_steady: assert property (
    host_rd && $past(host_rd) |=> $stable(host_rdata))
    else $error("read data moved during a read");
endmodule

bind ies_event_one ies_event_one_monitor #(.PORT_SEL(PORT_SEL)) u_monitor (.*);

// ===== dv/ies_bus_model.sv
// model: far bus party, state levels and acceptor handshake
module ies_bus_model (
  input wire logic clk,
  input wire logic acceptor_hold,
  output logic [7:0] bus_byte,
  output logic acds,
  output logic [19:0] st
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  logic age;
  logic [7:0] nb;

  // idle at time zero
  initial begin
    st = '0;
    req = 1'h0;
    age = 1'h0;
    nb = 8'h00;
    acds = 1'h0;
    bus_byte = 8'hff;
  end

  // acds lasts two cycles, longer while the device stalls the acceptor
  always @(posedge clk) begin
    age <= acds && !req;
    if (req) begin
      acds <= 1'h1;
    end else if (age && !acceptor_hold) begin
      acds <= 1'h0;
    end
    // a released data line inverts its byte on every cycle
    bus_byte <= req ? nb : (acds ? bus_byte : ~bus_byte);
  end

  // set state and classification levels
  task automatic put(input logic [19:0] v);
    @(posedge clk);
    st <= v;
  endtask

  // offer one byte to the acceptor
  task automatic take(input logic [7:0] b);
    @(posedge clk);
    nb <= b;
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
  endtask
endmodule

// ===== dv/tb_ieee488_event_status_one.sv
// testbench: first event group through its host registers and bus states
module tb_ieee488_event_status_one;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] EVT = ies_pkg::OFF_A_EVENT;
  localparam logic [4:0] AUX = ies_pkg::OFF_A_AUX;
  // state bits: tacs sgns sdys sids dac rfd lacs eoi dtas dcas tads lads tpas lpas ucg acg scg
  localparam logic [19:0] TV [6] = '{20'h00100, 20'h00200, 20'h00035, 20'h00003, 20'h00040,
    20'h000c0};
  localparam logic [7:0] TE [6] = '{8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'h11};
  logic clk, reset, host_rd, host_wr, irq, acceptor_hold, acds;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, host_rdata, bus_byte, pass_through_readback;
  logic pass_through_on, string_match_allow, address_mode_high, address_mode_low;
  logic continuous_mode, holdoff_mode, group_two_pending;
  logic tacs, sgns, sdys, sids, dac, rfd, lacs, eoi, dtas, dcas, tads, lads, tpas, lpas;
  logic ucg, acg, scg, tag, lag, cmd_defined;
  logic [19:0] st;
  int fail_count, checks_done;
  assign {cmd_defined, lag, tag, scg, acg, ucg, lpas, tpas, lads, tads, dcas, dtas, eoi, lacs,
    rfd, dac, sids, sdys, sgns, tacs} = st;

  ies_event_one #(.PORT_SEL(1'h0)) DUT (.*);
  ies_bus_model bm (.clk(clk), .acceptor_hold(acceptor_hold), .bus_byte(bus_byte), .acds(acds),
    .st(st));

  // 50 ns clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ==========
  // host access and comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'h1;
    @(posedge clk);
    host_wr <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    host_addr <= a;
    host_rd <= 1'h1;
    @(posedge clk);
    @(negedge clk);
    d = host_rdata;
    @(posedge clk);
    host_rd <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  // interrupt level, then status read
  task automatic look(input logic [7:0] es, input logic ei);
    logic [7:0] d;
    @(negedge clk);
    chk({7'h00, irq}, {7'h00, ei});
    rd(EVT, d);
    chk(d, es);
  endtask
  // one command byte; stall expected or not, released by the given code
  task automatic cmd(input logic [19:0] v, input logic [7:0] b, input logic h,
                     input logic [7:0] code);
    logic [7:0] d;
    bm.put(v);
    bm.take(b);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({7'h00, acceptor_hold}, {7'h00, h});
    if (h) begin
      chk(pass_through_readback, b);
      rd(AUX, d);
      chk(d, b);
      wr(AUX, code);
      @(negedge clk);
      chk({7'h00, acceptor_hold}, 8'h00);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========
  // tests
  initial begin
    logic [7:0] e;
    {host_addr, host_rd, host_wr, host_wdata} = '0;
    {pass_through_on, string_match_allow, address_mode_high, address_mode_low} = '0;
    {continuous_mode, holdoff_mode, group_two_pending} = '0;
    fail_count = 0;
    checks_done = 0;
    reset = 1'h1;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    look(8'h00, 1'h0);
    chk(pass_through_readback, 8'h00);
    $display("test reset done");
    // each flag but unknown and secondary with its enable off, on, and only the others on
    for (int j = 0; j < 3; j++) begin
      for (int i = 0; i < 6; i++) begin
        e = (j == 0) ? 8'h00 : (j == 1) ? TE[i] : ~TE[i];
        wr(EVT, e);
        bm.put(TV[i]);
        if (i > 3) bm.take(8'h5a);
        repeat (4) @(posedge clk);
        look(TE[i], j == 1);
        look(8'h00, 1'h0);
        bm.put('0);
      end
    end
    bm.put(20'h00008);
    wr(ies_pkg::OFF_A_DATA, 8'h33);
    look(8'h04, 1'h1);
    $display("test flags done");
    // trigger while status is being read
    wr(EVT, 8'hff);
    @(posedge clk);
    host_addr <= EVT;
    host_rd <= 1'h1;
    bm.put(20'h00100);
    @(negedge clk);
    chk(host_rdata, 8'h00);
    @(posedge clk);
    host_rd <= 1'h0;
    bm.put('0);
    look(8'h20, 1'h1);
    // data read clears the input byte flag
    bm.put(20'h00040);
    bm.take(8'h21);
    repeat (4) @(posedge clk);
    rd(ies_pkg::OFF_A_DATA, e);
    look(8'h00, 1'h0);
    // terminator match in continuous mode, then finish in holdoff mode
    wr(ies_pkg::OFF_A_TERM, 8'h0a);
    {string_match_allow, continuous_mode} <= 2'h3;
    bm.take(8'h0a);
    repeat (4) @(posedge clk);
    look(8'h10, 1'h1);
    {string_match_allow, continuous_mode, holdoff_mode} <= 3'h1;
    bm.take(8'h0b);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(AUX, ies_pkg::AUX_FINISH);
    look(8'h00, 1'h0);
    holdoff_mode <= 1'h0;
    group_two_pending <= 1'h1;
    repeat (2) @(posedge clk);
    look(8'h00, 1'h1);
    group_two_pending <= 1'h0;
    $display("test read timing done");
    // unknown commands, following secondaries, ignored and defined ones
    pass_through_on <= 1'h1;
    cmd(20'h04000, 8'h01, 1'h1, ies_pkg::AUX_VALID);
    look(8'h80, 1'h1);
    cmd(20'h10000, 8'h62, 1'h1, ies_pkg::AUX_VALID);
    look(8'h80, 1'h1);
    cmd(20'h84000, 8'h14, 1'h0, 8'h00);
    cmd(20'h10000, 8'h63, 1'h0, 8'h00);
    cmd(20'h08000, 8'h05, 1'h0, 8'h00);
    cmd(20'h08400, 8'h01, 1'h1, ies_pkg::AUX_NON_VALID);
    look(8'h80, 1'h1);
    cmd(20'h08800, 8'h04, 1'h1, ies_pkg::AUX_VALID);
    look(8'h80, 1'h1);
    cmd(20'h20000, 8'h41, 1'h0, 8'h00);
    cmd(20'h10000, 8'h64, 1'h0, 8'h00);
    look(8'h00, 1'h0);
    pass_through_on <= 1'h0;
    cmd(20'h04000, 8'h02, 1'h0, 8'h00);
    look(8'h00, 1'h0);
    // secondary address in mode 3
    {address_mode_high, address_mode_low} <= 2'h3;
    cmd(20'h11000, 8'h6a, 1'h1, ies_pkg::AUX_NON_VALID);
    look(8'h40, 1'h1);
    cmd(20'h12000, 8'h6b, 1'h1, ies_pkg::AUX_VALID);
    look(8'h40, 1'h1);
    $display("test pass-through done");
    summarize();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule
